// >>> hdl/conv_ctrl_pkg.sv
// constants shared by the conversion and read control logic
package conv_ctrl_pkg;
	localparam int RESULT_WIDTH = 16;
	localparam int RESULT_MSB = 15;
	localparam int RESULT_LSB = 0;
	localparam int CLK_HZ = 20000000;
	// conversion time in ns, and acquisition time in ns
	localparam int CONV_TIME_NS = 3300;
	localparam int ACQ_TIME_NS = 480;
	localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// bit decisions are spread evenly over the conversion time
	localparam int BIT_CYCLES = CONV_CYCLES / RESULT_WIDTH;
	localparam int CNT_WIDTH = 8;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONVERT = 2'b01,
		ST_DONE = 2'b10
	} conv_state_type;
endpackage : conv_ctrl_pkg

// >>> hdl/conv_read_ctrl.sv
// conversion sequencer, busy flag and three-state result port
`timescale 1ns/100ps

module conv_read_ctrl (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// host strobes (asynchronous pins)
	input wire logic i_select_n,
	input wire logic i_conversion_start_n,
	input wire logic i_read_n,
	// comparator decision from the analog core, same clock
	input wire logic i_comp_high,
	// status and data
	output logic o_busy_n,
	output logic [15:0] o_data,
	output logic [15:0] o_data_oe,
	// trial word driving the capacitive dac
	output logic [15:0] o_dac_word,
	output logic o_sample
);
	logic [2:0] pins_sync;
	logic select_n;
	logic start_n;
	logic read_n;
	logic start_prev_n;
	logic start_fall;
	conv_ctrl_pkg::conv_state_type state;
	logic [conv_ctrl_pkg::CNT_WIDTH-1:0] cycle_cnt;
	logic [3:0] bit_idx;
	logic [15:0] sar;
	logic [15:0] result;
	logic conv_begin;
	logic bit_end;
	logic last_bit;
	logic conv_done;
	logic [15:0] next_result;

	////////////////////////////////////////////////////////////////////////
	input_sync #(
		.WIDTH(3),
		.RESET_VALUE(3'h7)
	) u_sync (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_async({i_select_n, i_conversion_start_n, i_read_n}),
		.o_sync(pins_sync)
	);
	assign select_n = pins_sync[2];
	assign start_n = pins_sync[1];
	assign read_n = pins_sync[0];

	// edge seen on the synchronised strobe; select gates the start
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			start_prev_n <= 1'b1;
		end else begin
			start_prev_n <= start_n;
		end
	end
	assign start_fall = start_prev_n && !start_n && !select_n;

	////////////////////////////////////////////////////////////////////////
	// sequencer events, decoded once so every register below agrees on them
	assign conv_begin = (state == conv_ctrl_pkg::ST_IDLE) && start_fall;
	assign bit_end = (state == conv_ctrl_pkg::ST_CONVERT) &&
		(cycle_cnt == conv_ctrl_pkg::CNT_WIDTH'(conv_ctrl_pkg::BIT_CYCLES - 1));
	assign last_bit = bit_end && (bit_idx == 4'h0);
	assign conv_done = (state == conv_ctrl_pkg::ST_DONE);

	// msb inverted turns the offset binary trial word into two's complement
	always_comb begin
		next_result = {~sar[conv_ctrl_pkg::RESULT_MSB], sar[14:0]};
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer on the block's own clock; no host clock involved
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= conv_ctrl_pkg::ST_IDLE;
		end else begin
			unique case (state)
				conv_ctrl_pkg::ST_IDLE: begin
					if (start_fall) begin
						state <= conv_ctrl_pkg::ST_CONVERT;
					end
				end
				conv_ctrl_pkg::ST_CONVERT: begin
					// start edges fall through unheard here
					if (last_bit) begin
						state <= conv_ctrl_pkg::ST_DONE;
					end
				end
				conv_ctrl_pkg::ST_DONE: begin
					state <= conv_ctrl_pkg::ST_IDLE;
				end
				default: begin
					state <= conv_ctrl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// cycles within one bit decision; cleared at each decision so that
	// the counter is already at zero when the next conversion begins
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cycle_cnt <= '0;
		end else if (conv_begin || bit_end) begin
			cycle_cnt <= '0;
		end else if (state == conv_ctrl_pkg::ST_CONVERT) begin
			cycle_cnt <= cycle_cnt + 1'b1;
		end
	end

	// bit under trial, msb first
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bit_idx <= 4'h0;
		end else if (conv_begin) begin
			bit_idx <= 4'hF;
		end else if (bit_end && bit_idx != 4'h0) begin
			bit_idx <= bit_idx - 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// successive approximation; comparator read at end of each bit, and
	// the trial word has been on the dac for three of the four cycles of a bit period by then
	for (genvar b = 0; b < conv_ctrl_pkg::RESULT_WIDTH; b++) begin : g_sar_bit
		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				sar[b] <= conv_ctrl_pkg::RESULT_RESET[b];
			end else if (conv_begin) begin
				sar[b] <= (b == conv_ctrl_pkg::RESULT_MSB);
			end else if (bit_end && bit_idx == 4'(b) && !i_comp_high) begin
				sar[b] <= 1'b0;
			end else if (bit_end && b < conv_ctrl_pkg::RESULT_MSB && bit_idx == 4'(b + 1)) begin
				sar[b] <= 1'b1;
			end
		end
	end

	// latch loads only at completion
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			result <= conv_ctrl_pkg::RESULT_RESET;
		end else if (conv_done) begin
			result <= next_result;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// busy falls with the start and rises the cycle the new result is out
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_busy_n <= 1'b1;
		end else if (conv_begin) begin
			o_busy_n <= 1'b0;
		end else if (conv_done) begin
			o_busy_n <= 1'b1;
		end
	end

	// data register copies the latch; the old word stays out during conversion
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_data <= conv_ctrl_pkg::RESULT_RESET;
		end else begin
			o_data <= conv_done ? next_result : result;
		end
	end

	// drivers on only for read and select both low, whatever start does
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_data_oe <= 16'h0000;
		end else begin
			o_data_oe <= {16{!read_n && !select_n}};
		end
	end

	// trial word to the dac, one cycle behind the register
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_dac_word <= 16'h0000;
		end else begin
			o_dac_word <= sar;
		end
	end

	// hold starts in the cycle the start is taken, so the input cannot drift
	// while the first trial settles; acquisition resumes once idle again
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_sample <= 1'b1;
		end else begin
			o_sample <= (state == conv_ctrl_pkg::ST_IDLE) && !start_fall;
		end
	end
endmodule : conv_read_ctrl

// >>> hdl/input_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module input_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// pins
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta <= RESET_VALUE;
			o_sync <= RESET_VALUE;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule : input_sync

// >>> tb/analog_model.sv
// comparator model of the analog core
`timescale 1ns/100ps
module analog_model (
	input wire logic [15:0] i_level,
	input wire logic [15:0] i_dac_word,
	output logic o_comp_high
);
	// level is offset binary and held for the whole conversion
	assign o_comp_high = i_level >= i_dac_word;
endmodule : analog_model

// >>> tb/conv_read_ctrl_monitor.sv
// port assertions for the conversion control
`timescale 1ns/100ps
module conv_read_ctrl_monitor (
	input wire logic i_clk, i_arst_n, i_select_n, i_conversion_start_n, i_read_n,
	input wire logic o_busy_n, o_sample,
	input wire logic [15:0] o_data, o_data_oe, o_dac_word
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	sequence start_fell;
		$fell(i_conversion_start_n) && o_busy_n;
	endsequence
	sequence conv_ends;
		##64 !o_busy_n ##1 o_busy_n;
	endsequence
	AST_START: assert property (start_fell ##0 !i_select_n |-> ##[2:5] !o_busy_n)
		else $error("start missed");
	AST_DESEL: assert property (start_fell ##0 i_select_n |-> o_busy_n[*6])
		else $error("start taken while deselected");
	AST_BUSY: assert property ($fell(o_busy_n) |-> conv_ends)
		else $error("busy length wrong");
	AST_MSB: assert property ($fell(o_busy_n) |-> !o_sample ##1 o_dac_word == 16'h8000)
		else $error("bad first trial");
	AST_OE_ON: assert property ((!i_read_n && !i_select_n)[*4] |-> o_data_oe == 16'hFFFF)
		else $error("outputs not driven");
	AST_OE_OFF: assert property ((i_read_n || i_select_n)[*4] |-> o_data_oe == 16'h0000)
		else $error("outputs driven");
	AST_LATCH: assert property ($changed(o_data) |-> $rose(o_busy_n))
		else $error("result moved early");
	AST_IDLE: assert property (o_busy_n && $past(o_busy_n) |-> o_sample)
		else $error("not sampling when idle");
endmodule : conv_read_ctrl_monitor
////////////////////////////////////////
bind conv_read_ctrl conv_read_ctrl_monitor u_conv_read_ctrl_monitor (.i_clk(i_clk),
	.i_arst_n(i_arst_n), .i_select_n(i_select_n), .i_conversion_start_n(i_conversion_start_n),
	.i_read_n(i_read_n), .o_busy_n(o_busy_n), .o_sample(o_sample), .o_data(o_data),
	.o_data_oe(o_data_oe), .o_dac_word(o_dac_word));

// >>> tb/testbench.sv
// self-checking bench for the conversion control
`timescale 1ns/100ps
module testbench;
	localparam int CONV_LEN = conv_ctrl_pkg::RESULT_WIDTH * conv_ctrl_pkg::BIT_CYCLES + 1;
	logic clk = 1'b0, arst_n = 1'b0, sel_n = 1'b1, start_n = 1'b1, rd_n = 1'b1, comp, busy_n;
	logic [15:0] data, oe, dac, level = 16'h0000, prev = 16'h0000;
	int errors = 0, n_checks = 0, len;
	always #25 clk = ~clk;
	analog_model u_analog_model (.i_level(level), .i_dac_word(dac), .o_comp_high(comp));
	conv_read_ctrl u_conv_read_ctrl (.i_clk(clk), .i_arst_n(arst_n), .i_select_n(sel_n),
		.i_conversion_start_n(start_n), .i_read_n(rd_n), .i_comp_high(comp),
		.o_busy_n(busy_n), .o_data(data), .o_data_oe(oe), .o_dac_word(dac), .o_sample());
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask : check
	// hold < 0 keeps the strobe low until busy rises; poke retries mid-run
	task automatic convert(input logic [15:0] val, input int hold, input bit tied, input bit poke);
		level = val;
		len = 0;
		for (int i = 0; i < 300; i++) begin
			@(negedge clk);
			start_n = hold < 0 ? len > 0 && busy_n : !(i < hold || poke && i inside {[20:21]});
			if (tied) rd_n = start_n;
			if (tied && len == 9) check(hold < 0 ? oe & data : data, prev);
			if (!busy_n) len++;
			if (len > 0 && busy_n) break;
		end
		prev = val ^ 16'h8000;
		check(data, prev);
		check(16'(len), 16'(CONV_LEN));
	endtask : convert
	task automatic t_mode1();
		rd_n = 1'b0;
		convert(16'h0000, 2, 0, 0);
		convert(16'hFFFF, 2, 0, 1);
		check(oe, 16'hFFFF);
		$display("mode1 done");
	endtask : t_mode1
	task automatic t_read();
		rd_n = 1'b1;
		convert(16'h8001, 2, 0, 0);
		check(oe, 16'h0000);
		rd_n = 1'b0;
		repeat (4) @(negedge clk);
		check(oe, 16'hFFFF);
		sel_n = 1'b1;
		start_n = 1'b0;
		repeat (6) @(negedge clk);
		check(oe | 16'(busy_n), 16'h0001);
		start_n = 1'b1;
		sel_n = 1'b0;
		$display("read done");
	endtask : t_read
	task automatic t_tied();
		convert(16'h1234, -1, 1, 0);
		convert(16'hC0DE, 2, 1, 0);
		$display("tied done");
	endtask : t_tied
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test
	////////////////////////////////////////
	initial begin
		repeat (8) @(negedge clk);
		arst_n = 1'b1;
		sel_n = 1'b0;
		t_mode1();
		t_read();
		t_tied();
		end_of_test();
	end
	// about four times the expected run
	initial begin
		#(50 * 1500);
		errors++;
		end_of_test();
	end
endmodule : testbench
